/* File: core/dba_pkg.sv */
// constants and types for the display buffer access command block
// Function
// RULE1 - Command A4 reads the buffer at the pointer address into the latch, and A2 writes the latch there.
// RULE2 - Command A9 adds one to the cursor address modulo 16k with no memory transfer.
// RULE3 - Command AC reads the buffer at the cursor address into the latch, and AA writes the latch there.
// RULE4 - Commands AD and AB do the cursor read or write and then add one to the cursor modulo 16k.
// RULE5 - Command BB writes the latch into every location from cursor through pointer inclusive.
// RULE6 - After the fill the pointer is unchanged and the cursor equals the pointer.
// RULE7 - Without interlace only the even field is produced, over and over.
// RULE8 - With interlace even and odd fields alternate field by field.
// RULE9 - A host access may be strobed by chip enable, its falling and rising edges acting as the strobe edges.
// RULE10 - The host keeps chip enable high between successive accesses.
// RULE11 - Transfer commands wait for horizontal blanking during active display, and run at once in retrace or display off.
// RULE12 - Increment and fill start at once, the increment finishing within about three character clocks.
// RULE13 - The fill holds blanking asserted until horizontal blanking begins after the last write.
// RULE14 - Ready and accept flags are set on completion, and the host waits for them before another command.
// RULE15 - After a read the latch keeps the fetched byte until a host write or transfer overwrites it.
// RULE16 - The accept flag clears when a delayed command is taken and stays clear until its transfers finish; the code leaves it set for A9.
package dba_pkg;
    localparam int          ADDR_W      = 14;
    localparam int          DATA_W      = 8;
    localparam logic [7:0]  CMD_RD_PTR  = 8'hA4;
    localparam logic [7:0]  CMD_WR_PTR  = 8'hA2;
    localparam logic [7:0]  CMD_INC_CUR = 8'hA9;
    localparam logic [7:0]  CMD_RD_CUR  = 8'hAC;
    localparam logic [7:0]  CMD_WR_CUR  = 8'hAA;
    localparam logic [7:0]  CMD_RD_INC  = 8'hAD;
    localparam logic [7:0]  CMD_WR_INC  = 8'hAB;
    localparam logic [7:0]  CMD_FILL    = 8'hBB;
    localparam logic [13:0] ADDR_ONE    = 14'h0001;
    localparam logic [13:0] ADDR_RESET  = 14'h0000;
    localparam logic [7:0]  DATA_RESET  = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_HBLANK,
        ST_FILL,
        ST_FILL_END
    } state_t;
endpackage

/* File: core/dba_strobe_if.sv */
// strobe edge carrier between the top and its edge detector
`timescale 1ns/1ps
interface dba_strobe_if;
    logic write_done;
    logic read_done;
    modport det (output write_done, output read_done);
    modport use_side (input write_done, input read_done);
endinterface

/* File: core/dba_strobe_det.sv */
// turns host strobe levels into end-of-access pulses
`timescale 1ns/1ps
module dba_strobe_det (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_ce_n,
    input  wire logic  i_wr_n,
    input  wire logic  i_rd_n,
    dba_strobe_if.det  bus
);
    logic wr_act;
    logic rd_act;
    logic wr_prev;
    logic rd_prev;

    // chip enable low qualifies, so ce alone may act as strobe
    assign wr_act = !i_ce_n && !i_wr_n; // see RULE9
    assign rd_act = !i_ce_n && !i_rd_n; // see RULE9

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
        end else begin
            wr_prev <= wr_act;
            rd_prev <= rd_act;
        end
    end

    // trailing edge ends the access; needs ce high between cycles
    assign bus.write_done = wr_prev && !wr_act; // see RULE10
    assign bus.read_done  = rd_prev && !rd_act;
endmodule

/* File: core/dba_cmd.sv */
// delayed display buffer access command interpreter
`timescale 1ns/1ps
module dba_cmd
    import dba_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_CE_N,
    input  wire logic              I_WR_N,
    input  wire logic              I_RD_N,
    input  wire logic              I_CMD_SEL,
    input  wire logic [DATA_W-1:0] I_DATA,
    input  wire logic [ADDR_W-1:0] I_PTR_LOAD,
    input  wire logic              I_PTR_LOAD_EN,
    input  wire logic [ADDR_W-1:0] I_CUR_LOAD,
    input  wire logic              I_CUR_LOAD_EN,
    input  wire logic              I_ACTIVE_DISPLAY,
    input  wire logic              I_HBLANK_START,
    input  wire logic              I_FIELD_START,
    input  wire logic              I_INTERLACE,
    input  wire logic [DATA_W-1:0] I_MEM_RDATA,
    output logic [ADDR_W-1:0]      O_MEM_ADDR,
    output logic [DATA_W-1:0]      O_MEM_WDATA,
    output logic                   O_MEM_WE,
    output logic                   O_MEM_RE,
    output logic [DATA_W-1:0]      O_LATCH,
    output logic [ADDR_W-1:0]      O_CURSOR,
    output logic [ADDR_W-1:0]      O_POINTER,
    output logic                   O_COMMAND_ACCEPT_FLAG,
    output logic                   O_READY,
    output logic                   O_FILL_BLANK,
    output logic                   O_ODD_FIELD
);
    dba_strobe_if strobe ();

    state_t            state;
    logic [7:0]        cmd;
    logic              read_pending;
    logic              new_cmd;
    logic              is_delayed;
    logic              is_read;
    logic              use_cursor;
    logic              post_inc;
    logic [ADDR_W-1:0] xfer_addr;
    logic              xfer_go;
    logic              fill_last;

    dba_strobe_det u_det (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_ce_n  (I_CE_N),
        .i_wr_n  (I_WR_N),
        .i_rd_n  (I_RD_N),
        .bus     (strobe.det)
    );

    ////////////////////////////////////////////////////////////////////////
    // command decode

    assign new_cmd = strobe.write_done && I_CMD_SEL && state == ST_IDLE;

    always_comb begin
        is_delayed = 1'b1;
        case (I_DATA)
            CMD_RD_PTR, CMD_WR_PTR, CMD_INC_CUR, CMD_RD_CUR,
            CMD_WR_CUR, CMD_RD_INC, CMD_WR_INC, CMD_FILL: is_delayed = 1'b1;
            default: is_delayed = 1'b0;
        endcase
    end

    assign is_read    = cmd == CMD_RD_PTR || cmd == CMD_RD_CUR || cmd == CMD_RD_INC;
    assign use_cursor = cmd != CMD_RD_PTR && cmd != CMD_WR_PTR;
    assign post_inc   = cmd == CMD_RD_INC || cmd == CMD_WR_INC;
    assign xfer_addr  = use_cursor ? O_CURSOR : O_POINTER; // see RULE1 see RULE3
    // transfers stall to horizontal blanking only while picture is shown
    assign xfer_go    = !I_ACTIVE_DISPLAY || I_HBLANK_START; // see RULE11
    assign fill_last  = O_CURSOR == O_POINTER;

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state <= ST_IDLE;
            cmd   <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (new_cmd && is_delayed) begin
                        cmd <= I_DATA;
                        // increment and fill skip the blanking wait
                        if (I_DATA == CMD_FILL) begin
                            state <= ST_FILL; // see RULE12
                        end else if (I_DATA != CMD_INC_CUR) begin
                            state <= ST_WAIT_HBLANK;
                        end
                    end
                end
                ST_WAIT_HBLANK: begin
                    if (xfer_go) begin
                        state <= ST_IDLE;
                    end
                end
                ST_FILL: begin
                    if (fill_last) begin
                        state <= ST_FILL_END;
                    end
                end
                ST_FILL_END: begin
                    if (I_HBLANK_START) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory port, one access per clock

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_MEM_ADDR  <= ADDR_RESET;
            O_MEM_WDATA <= DATA_RESET;
            O_MEM_WE    <= 1'b0;
            O_MEM_RE    <= 1'b0;
        end else begin
            O_MEM_WE    <= 1'b0;
            O_MEM_RE    <= 1'b0;
            O_MEM_WDATA <= O_LATCH;
            if (state == ST_WAIT_HBLANK && xfer_go) begin
                O_MEM_ADDR <= xfer_addr;
                O_MEM_WE   <= !is_read; // see RULE1 see RULE3
                O_MEM_RE   <= is_read;
            end else if (state == ST_FILL) begin
                O_MEM_ADDR <= O_CURSOR; // see RULE5
                O_MEM_WE   <= 1'b1;
            end
        end
    end

    // read data returns the cycle after the strobe
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            read_pending <= 1'b0;
        end else begin
            read_pending <= O_MEM_RE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus interface latch

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_LATCH <= DATA_RESET;
        end else if (read_pending) begin
            O_LATCH <= I_MEM_RDATA; // see RULE15
        end else if (strobe.write_done && !I_CMD_SEL) begin
            O_LATCH <= I_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address registers

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_CURSOR <= ADDR_RESET;
        end else if (state == ST_IDLE && new_cmd && I_DATA == CMD_INC_CUR) begin
            O_CURSOR <= O_CURSOR + ADDR_ONE; // see RULE2 see RULE12
        end else if (state == ST_WAIT_HBLANK && xfer_go && post_inc) begin
            O_CURSOR <= O_CURSOR + ADDR_ONE; // see RULE4
        end else if (state == ST_FILL && !fill_last) begin
            // stops on the pointer so cursor ends equal to it
            O_CURSOR <= O_CURSOR + ADDR_ONE; // see RULE5 see RULE6
        end else if (state == ST_IDLE && I_CUR_LOAD_EN) begin
            O_CURSOR <= I_CUR_LOAD;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_POINTER <= ADDR_RESET;
        end else if (state == ST_IDLE && I_PTR_LOAD_EN) begin
            O_POINTER <= I_PTR_LOAD; // see RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake flags and fill blanking

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_COMMAND_ACCEPT_FLAG <= 1'b1;
            O_READY               <= 1'b0;
        end else if (new_cmd && is_delayed && I_DATA != CMD_INC_CUR) begin
            O_COMMAND_ACCEPT_FLAG <= 1'b0; // see RULE16
            O_READY               <= 1'b0;
        end else if (new_cmd && is_delayed) begin
            O_READY               <= 1'b1; // see RULE14
        end else if ((state == ST_WAIT_HBLANK && xfer_go && !is_read) || read_pending
                     || (state == ST_FILL_END && I_HBLANK_START)) begin
            O_COMMAND_ACCEPT_FLAG <= 1'b1; // see RULE14
            O_READY               <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_FILL_BLANK <= 1'b0;
        end else if (state == ST_IDLE && new_cmd && I_DATA == CMD_FILL) begin
            O_FILL_BLANK <= 1'b1; // see RULE13
        end else if (state == ST_FILL_END && I_HBLANK_START) begin
            O_FILL_BLANK <= 1'b0; // see RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field sequencing

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_ODD_FIELD <= 1'b0;
        end else if (!I_INTERLACE) begin
            O_ODD_FIELD <= 1'b0; // see RULE7
        end else if (I_FIELD_START) begin
            O_ODD_FIELD <= !O_ODD_FIELD; // see RULE8
        end
    end
endmodule

/* File: bench/buf_mem_model.sv */
// display buffer memory on the far side
`timescale 1ns/1ps
module buf_mem_model (
    input  wire logic        i_clk,
    input  wire logic [13:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_we,
    input  wire logic        i_re,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem [0:16383];
    logic [7:0] rd_q;
    logic       re_q;
    always_ff @(posedge i_clk) begin
        if (i_we)
            mem[i_addr] <= i_wdata;
        if (i_re)
            rd_q <= mem[i_addr];
        re_q <= i_re;
    end
    // stale byte inverted outside a read so it never passes by luck
    assign o_rdata = i_re ? mem[i_addr] : (re_q ? rd_q : ~rd_q);
endmodule

/* File: bench/dba_cmd_properties.sv */
// port-level checks for the buffer access command block
`timescale 1ns/1ps
module dba_cmd_properties
    import dba_pkg::*;
(
    input wire logic              I_CLK,
    input wire logic              I_RST_N,
    input wire logic              I_CUR_LOAD_EN,
    input wire logic              I_HBLANK_START,
    input wire logic              I_FIELD_START,
    input wire logic              I_INTERLACE,
    input wire logic [DATA_W-1:0] O_MEM_WDATA,
    input wire logic              O_MEM_WE,
    input wire logic              O_MEM_RE,
    input wire logic [DATA_W-1:0] O_LATCH,
    input wire logic [ADDR_W-1:0] O_CURSOR,
    input wire logic [ADDR_W-1:0] O_POINTER,
    input wire logic              O_COMMAND_ACCEPT_FLAG,
    input wire logic              O_READY,
    input wire logic              O_FILL_BLANK,
    input wire logic              O_ODD_FIELD
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    ////////////////////////////////////////////////////////////
    sequence s_fill_end;
        O_FILL_BLANK ##1 !O_FILL_BLANK;
    endsequence
    sequence s_done;
        O_COMMAND_ACCEPT_FLAG && O_READY;
    endsequence
    a_write_data: assert property (
        O_MEM_WE |-> O_MEM_WDATA == $past(O_LATCH)) else $error("bad write data");
    a_cursor_step: assert property (
        $past(I_RST_N) && !$past(I_CUR_LOAD_EN) && $changed(O_CURSOR) |-> O_CURSOR == $past(O_CURSOR) + ADDR_ONE)
        else $error("bad cursor step");
    a_write_done: assert property (
        O_MEM_WE && !O_FILL_BLANK |-> s_done ##1 !O_MEM_WE) else $error("write not done");
    a_read_done: assert property (
        O_MEM_RE |=> !O_MEM_RE ##1 s_done) else $error("read not done");
    a_fill_busy: assert property (
        O_FILL_BLANK |-> !O_COMMAND_ACCEPT_FLAG && !O_READY) else $error("fill not busy");
    a_fill_hblank: assert property (
        s_fill_end |-> $past(I_HBLANK_START)) else $error("blank freed early");
    a_fill_cursor: assert property (
        s_fill_end |-> O_CURSOR == O_POINTER) else $error("fill cursor off");
    a_fill_ready: assert property (
        s_fill_end |=> s_done) else $error("fill not done");
    a_ptr_hold: assert property (
        !O_COMMAND_ACCEPT_FLAG |=> $stable(O_POINTER)) else $error("pointer moved");
    a_field_seq: assert property (
        I_FIELD_START |=> O_ODD_FIELD == ($past(I_INTERLACE) && !$past(O_ODD_FIELD))) else $error("bad field");
endmodule
bind dba_cmd dba_cmd_properties chk (.I_CLK, .I_RST_N, .I_CUR_LOAD_EN, .I_HBLANK_START, .I_FIELD_START,
    .I_INTERLACE, .O_MEM_WDATA, .O_MEM_WE, .O_MEM_RE, .O_LATCH, .O_CURSOR, .O_POINTER,
    .O_COMMAND_ACCEPT_FLAG, .O_READY, .O_FILL_BLANK, .O_ODD_FIELD);

/* File: bench/dba_cmd_test.sv */
// self-checking bench for the buffer access command block
`timescale 1ns/1ps
module dba_cmd_test;
    import dba_pkg::*;
    logic        clk, rst_n, ce_n, wr_n, sel, pen, cen, act, hbl, fst, il, we, re, flag, rdy, blank, odd, f;
    logic [7:0]  data, rdata, wdata, latch, b0, b1;
    logic [13:0] pld, cld, maddr, cursor, pointer, p, c;
    int          error_cnt, checks_done, n, m;

    dba_cmd dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE_N(ce_n), .I_WR_N(wr_n), .I_RD_N(1'b1),
        .I_CMD_SEL(sel), .I_DATA(data), .I_PTR_LOAD(pld), .I_PTR_LOAD_EN(pen), .I_CUR_LOAD(cld),
        .I_CUR_LOAD_EN(cen), .I_ACTIVE_DISPLAY(act), .I_HBLANK_START(hbl), .I_FIELD_START(fst),
        .I_INTERLACE(il), .I_MEM_RDATA(rdata), .O_MEM_ADDR(maddr), .O_MEM_WDATA(wdata), .O_MEM_WE(we),
        .O_MEM_RE(re), .O_LATCH(latch), .O_CURSOR(cursor), .O_POINTER(pointer),
        .O_COMMAND_ACCEPT_FLAG(flag), .O_READY(rdy), .O_FILL_BLANK(blank), .O_ODD_FIELD(odd));
    buf_mem_model mem (.i_clk(clk), .i_addr(maddr), .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    function automatic logic [13:0] adv(input logic [13:0] a, input int k);
        return 14'(a + k);
    endfunction
    task automatic check(input logic ok, input string s);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic load(input logic [13:0] pv, input logic [13:0] cv);
        pld = pv;
        cld = cv;
        pen = 1;
        cen = 1;
        tick(1);
        pen = 0;
        cen = 0;
    endtask
    task automatic host_wr(input logic s, input logic [7:0] d);
        sel = s;
        data = d;
        ce_n = 0;
        wr_n = 0;
        tick(1);
        ce_n = 1;
        wr_n = 1'($urandom_range(1));
        tick(1);
        // wr may stay low, so the next access is strobed by ce alone
    endtask
    task automatic wait_done;
        n = 0;
        tick(2);
        while (!(flag === 1 && rdy === 1) && n < 300) begin
            tick(1);
            n++;
        end
        check(n < 300, "no completion");
    endtask
    task automatic cmd(input logic [7:0] op);
        host_wr(1, op);
        wait_done();
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {ce_n, wr_n, rst_n, sel, pen, cen, act, hbl, fst, il, f} = 11'h600;
        {data, pld, cld} = '0;
        b0 = 8'($urandom(32'hF276F24E));
        tick(8);
        rst_n = 1;
        check(flag === 1 && rdy === 0 && cursor === ADDR_RESET, "reset");
        p = {1'b0, 13'($urandom)};
        b1 = ~b0;
        load(p, 14'h3FFF);
        host_wr(0, b0);
        cmd(CMD_WR_PTR);
        check(mem.mem[p] === b0, "write ptr");
        host_wr(0, b1);
        cmd(CMD_RD_PTR);
        tick(5);
        check(latch === b0, "read ptr");
        cmd(CMD_WR_INC);
        check(mem.mem[14'h3FFF] === b0 && cursor === adv(14'h3FFF, 1), "write inc");
        host_wr(0, b1);
        cmd(CMD_WR_CUR);
        check(mem.mem[0] === b1 && cursor === 14'h0000, "write cur");
        cmd(CMD_INC_CUR);
        check(cursor === 14'h0001, "increment");
        load(p, 14'h3FFF);
        cmd(CMD_RD_INC);
        check(latch === b0 && cursor === 14'h0000, "read inc");
        cmd(CMD_RD_CUR);
        check(latch === b1, "read cur");
        $display("done: single transfers");
        host_wr(1, 8'h3C);
        tick(3);
        check(flag === 1 && cursor === 14'h0000 && latch === b1, "ignored");
        act = 1;
        host_wr(1, CMD_WR_PTR);
        tick(10);
        check(flag === 0 && mem.mem[p] === b0, "held");
        pulse(hbl);
        wait_done();
        check(mem.mem[p] === b1, "in blanking");
        act = 0;
        $display("done: active display");
        for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 14'h3FFD : 14'($urandom);
            m = (k == 1) ? 0 : $urandom_range(5);
            p = adv(c, m);
            b0 = 8'($urandom);
            load(p, c);
            host_wr(0, b0);
            host_wr(1, CMD_FILL);
            tick(m + 6);
            check(blank === 1, "blank");
            pulse(hbl);
            wait_done();
            check(blank === 0 && cursor === p && pointer === p, "fill end");
            for (int i = 0; i <= m; i++)
                check(mem.mem[adv(c, i)] === b0, "fill data");
        end
        $display("done: fill");
        for (int k = 0; k < 8; k++) begin
            il = k[2];
            f = il && !f;
            pulse(fst);
            tick(1);
            check(odd === f, "field");
        end
        $display("done: fields");
        final_report();
    end
    initial begin
        #(100 * 30000);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        final_report();
    end
endmodule
